// ### core/uart_mode_pkg.sv
// constants, field layout and encodings of the serial port mode block
// assumes a 16-bit register port with indexed addresses and one 10 MHz clock
// =========================================================================
// Operation
// RULE1 - The receive line idles high unless the polarity-invert bit (mode bit 4, reset 0) is set.
// RULE2 - Any departure of the receive line from its idle level starts start-bit detection.
// RULE3 - Sleep stops the sampling clock, so the first character after a line wake-up is invalid.
// RULE4 - With wake set, sleep still samples the line, flags its fall, and clears wake on next rise.
// RULE5 - Mode bit 11 set puts the request pin in simplex use, clear puts it in flow control.
// RULE6 - The infrared codec works only in the 16x rate mode, with high-speed select at 0.
// RULE7 - Module enable at 0 releases the pins and idles the logic, at 1 pins follow pin select.
package uart_mode_pkg;
  // =======================================================================
  // register port
  localparam int           ADDR_W       = 3;
  localparam logic [2:0]   ADDR_MODE    = 3'h0;
  localparam logic [2:0]   ADDR_STATUS  = 3'h1;
  localparam logic [2:0]   ADDR_TXDATA  = 3'h2;
  localparam logic [2:0]   ADDR_RXDATA  = 3'h3;
  localparam logic [2:0]   ADDR_RATE    = 3'h4;
  // =======================================================================
  // mode register fields
  localparam logic [15:0]  MODE_RESET   = 16'h0000;
  localparam logic [15:0]  MODE_WMASK   = 16'hbbff;
  localparam int           ENABLE_BIT   = 15;
  localparam int           STOP_IDLE_BIT = 13;
  localparam int           IR_BIT       = 12;
  localparam int           RTS_MODE_BIT = 11;
  localparam int           PIN_SEL_MSB  = 9;
  localparam int           PIN_SEL_LSB  = 8;
  localparam int           WAKE_BIT     = 7;
  localparam int           LOOP_BIT     = 6;
  localparam int           AUTO_RATE_BIT = 5;
  localparam int           RX_INV_BIT   = 4;
  localparam int           HIGH_SPEED_BIT = 3;
  localparam int           FMT_MSB      = 2;
  localparam int           FMT_LSB      = 1;
  localparam int           STOP_SEL_BIT = 0;
  // =======================================================================
  // status and receive word fields, rate register reset
  localparam int           STAT_AVAIL_BIT   = 0;
  localparam int           STAT_TX_BUSY_BIT = 1;
  localparam int           STAT_RX_BUSY_BIT = 2;
  localparam int           STAT_OVERRUN_BIT = 3;
  localparam int           RX_WORD_W        = 12;
  localparam logic [15:0]  RATE_RESET       = 16'h0000;
  // =======================================================================
  // bit timing in rate ticks, and last data bit index per format
  localparam logic [4:0]   TICKS_NORMAL   = 5'h10;
  localparam logic [4:0]   TICKS_FAST     = 5'h04;
  localparam logic [4:0]   IR_PULSE_TICKS = 5'h03;
  localparam logic [3:0]   EIGHT_LAST     = 4'h7;
  localparam logic [3:0]   NINE_LAST      = 4'h8;

  typedef enum logic [1:0] {
    PINS_TXRX    = 2'b00,
    PINS_RTS     = 2'b01,
    PINS_RTS_CTS = 2'b10,
    PINS_CLK     = 2'b11
  } pin_sel_t;

  typedef enum logic [1:0] {
    FMT_8N = 2'b00,
    FMT_8E = 2'b01,
    FMT_8O = 2'b10,
    FMT_9N = 2'b11
  } frame_fmt_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100,
    ST_STOP2  = 3'b101
  } line_state_t;
endpackage : uart_mode_pkg

// ### core/pin_sync.sv
// two-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to i_clk
`timescale 1ns/1ns
module pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         i_clk,   // clock
  input  wire logic         i_rst_b, // async reset, low
  input  wire logic [W-1:0] i_d,     // raw pins
  output logic      [W-1:0] o_q      // synchronised
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= RST;
      o_q  <= RST;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : pin_sync

// ### core/word_buffer.sv
// small fifo with valid and ready on both sides
// assumes power-of-two depth; a stalled drain holds the fill side off
`timescale 1ns/1ns
module word_buffer #(
  parameter int W     = 12,
  parameter int DEPTH = 2
) (
  input  wire logic         i_clk,       // clock
  input  wire logic         i_rst_b,     // async reset, low
  input  wire logic         i_in_valid,  // word offered
  output logic              o_in_ready,  // room for a word
  input  wire logic [W-1:0] i_in_data,   // word in
  output logic              o_out_valid, // word held
  input  wire logic         i_out_ready, // drain takes word
  output logic      [W-1:0] o_out_data   // head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("word_buffer depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  wire           push = i_in_valid & o_in_ready;
  wire           pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = (count != (PW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : word_buffer

// ### core/uart_mode_control.sv
// serial port with mode register, wake-up, pin control and infrared codec
// assumes a single-cycle register port, pins synchronised here, 10 MHz clock
`timescale 1ns/1ns
module uart_mode_control #(
  parameter int RATE_W    = 16,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                             i_clk,          // 10 MHz clock
  input  wire logic                             i_rst_b,        // async reset, low
  input  wire logic [uart_mode_pkg::ADDR_W-1:0] i_addr,         // register index
  input  wire logic [15:0]                      i_wdata,        // write data
  input  wire logic                             i_wr,           // write strobe
  input  wire logic                             i_rd,           // read strobe
  output logic      [15:0]                      o_rdata,        // read data, next cycle
  input  wire logic                             i_sleep,        // device asleep
  input  wire logic                             i_idle,         // device idle
  input  wire logic                             i_receive_line, // receive pin
  input  wire logic                             i_cts_b,        // clear to send, low
  output logic                                  o_tx,           // transmit pin level
  output logic                                  o_tx_oe,        // transmit pin driven
  output logic                                  o_request_to_send_line_b, // request, low
  output logic                                  o_request_oe,   // request pin driven
  output logic                                  o_bclk,         // rate clock out
  output logic                                  o_bclk_oe,      // rate clock pin driven
  output logic                                  o_wake_irq      // wake event pulse
);
  import uart_mode_pkg::*;

  if (RATE_W < 1 || RATE_W > 16) begin : g_bad_rate
    $error("uart_mode_control rate width must be 1 to 16");
  end

  // =======================================================================
  // mode fields
  logic [15:0]       serial_port_mode_reg;
  logic [RATE_W-1:0] rate_div;
  wire port_module_enable      = serial_port_mode_reg[ENABLE_BIT];
  wire stop_when_idle          = serial_port_mode_reg[STOP_IDLE_BIT];
  wire infrared_codec_enable   = serial_port_mode_reg[IR_BIT];
  wire request_pin_mode        = serial_port_mode_reg[RTS_MODE_BIT];
  wire wake_enable             = serial_port_mode_reg[WAKE_BIT];
  wire loop_back_enable        = serial_port_mode_reg[LOOP_BIT];
  wire receive_polarity_invert = serial_port_mode_reg[RX_INV_BIT];
  wire high_speed_rate_select  = serial_port_mode_reg[HIGH_SPEED_BIT];
  wire stop_bit_select         = serial_port_mode_reg[STOP_SEL_BIT];
  wire pin_sel_t pin_usage_select =
    pin_sel_t'(serial_port_mode_reg[PIN_SEL_MSB:PIN_SEL_LSB]);
  wire frame_fmt_t parity_width_select =
    frame_fmt_t'(serial_port_mode_reg[FMT_MSB:FMT_LSB]);

  // =======================================================================
  // pins, timing base
  logic [1:0] pins_s;
  pin_sync #(.W(2), .RST(2'b11)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({i_cts_b, i_receive_line}),
    .o_q     (pins_s)
  );
  wire rx_pin_s = pins_s[0];
  wire cts_b_s  = pins_s[1];

  // sleep, or idle with stop set, stands for stopped peripheral clocks
  wire frozen = i_sleep | (stop_when_idle & i_idle);                      // [RULE3]
  wire run    = port_module_enable & ~frozen;                             // [RULE7]

  logic [RATE_W-1:0] brg_cnt;
  wire        tick     = run & (brg_cnt == rate_div);
  wire        ir_on    = infrared_codec_enable & ~high_speed_rate_select; // [RULE6]
  wire [4:0]  tpb      = high_speed_rate_select ? TICKS_FAST : TICKS_NORMAL;
  wire [4:0]  half_m1  = (tpb >> 1) - 5'h01;
  wire [4:0]  bit_m1   = tpb - 5'h01;
  wire        fmt9     = (parity_width_select == FMT_9N);
  wire        has_par  = (parity_width_select == FMT_8E) |
                         (parity_width_select == FMT_8O);
  wire        odd_par  = (parity_width_select == FMT_8O);
  wire [3:0]  last_bit = fmt9 ? NINE_LAST : EIGHT_LAST;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brg_cnt <= '0;
    end else if (!port_module_enable) begin
      brg_cnt <= '0;
    end else if (run) begin
      brg_cnt <= tick ? '0 : brg_cnt + 1'b1;
    end
  end

  // =======================================================================
  // transmitter
  line_state_t tx_state;
  logic [4:0]  tx_cnt;
  logic [3:0]  tx_idx;
  logic [8:0]  tx_shift;
  logic        tx_parb;
  logic        tx_pend;
  wire tx_wr   = i_wr & (i_addr == ADDR_TXDATA);
  wire tx_busy = tx_pend | (tx_state != ST_IDLE);
  wire cts_ok  = (pin_usage_select != PINS_RTS_CTS) | ~cts_b_s;
  wire tx_step = tick & (tx_cnt == bit_m1);
  wire tx_level = (tx_state == ST_START)  ? 1'b0 :
                  (tx_state == ST_DATA)   ? tx_shift[tx_idx] :
                  (tx_state == ST_PARITY) ? tx_parb : 1'b1;
  // a zero bit becomes a short pulse in the first ticks of the bit
  wire tx_enc = ir_on ? (tx_level | (tx_cnt >= IR_PULSE_TICKS)) : tx_level; // [RULE6]

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state <= ST_IDLE;
      tx_cnt   <= 5'h00;
      tx_idx   <= 4'h0;
      tx_shift <= 9'h000;
      tx_parb  <= 1'b0;
      tx_pend  <= 1'b0;
    end else if (!port_module_enable) begin
      tx_state <= ST_IDLE;                                                // [RULE7]
      tx_pend  <= 1'b0;
    end else begin
      // a write while busy is dropped; software polls the busy flag
      if (tx_wr && !tx_busy) begin
        tx_shift <= {i_wdata[8] & fmt9, i_wdata[7:0]};
        tx_parb  <= (^i_wdata[7:0]) ^ odd_par;
        tx_pend  <= 1'b1;
      end
      if (run) begin
        if (tx_state == ST_IDLE) tx_cnt <= 5'h00;
        else if (tick) tx_cnt <= tx_step ? 5'h00 : tx_cnt + 5'h01;
        case (tx_state)
          ST_IDLE: begin
            if (tx_pend && cts_ok) begin
              tx_state <= ST_START;
              tx_pend  <= 1'b0;
            end
          end
          ST_START: begin
            if (tx_step) begin
              tx_idx   <= 4'h0;
              tx_state <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_step) begin
              tx_idx <= tx_idx + 4'h1;
              if (tx_idx == last_bit) tx_state <= has_par ? ST_PARITY : ST_STOP;
            end
          end
          ST_PARITY: if (tx_step) tx_state <= ST_STOP;
          ST_STOP:   if (tx_step) tx_state <= stop_bit_select ? ST_STOP2 : ST_IDLE;
          ST_STOP2:  if (tx_step) tx_state <= ST_IDLE;
          default:   tx_state <= ST_IDLE;
        endcase
      end
    end
  end

  // =======================================================================
  // receive line conditioning
  wire rx_raw  = loop_back_enable ? tx_level : rx_pin_s;
  wire rx_norm = rx_raw ^ receive_polarity_invert;                        // [RULE1]
  logic [4:0] ir_cnt;
  // a short infrared pulse is stretched to one bit time
  wire rx_bit = ir_on ? (rx_norm & (ir_cnt == 5'h00)) : rx_norm;          // [RULE6]

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_cnt <= 5'h00;
    end else if (!ir_on || !run) begin
      ir_cnt <= 5'h00;
    end else if (!rx_norm) begin
      ir_cnt <= tpb;
    end else if (tick && ir_cnt != 5'h00) begin
      ir_cnt <= ir_cnt - 5'h01;
    end
  end

  // =======================================================================
  // receiver
  line_state_t rx_state;
  logic [4:0]  rx_cnt;
  logic [3:0]  rx_idx;
  logic [8:0]  rx_shift;
  logic        rx_perr;
  logic        rx_desync;
  logic        buf_room;
  logic        buf_avail;
  logic [RX_WORD_W-1:0] buf_word;
  wire rx_samp = tick & (rx_cnt == ((rx_state == ST_START) ? half_m1 : bit_m1));
  wire rx_done = run & (rx_state == ST_STOP) & rx_samp;
  wire rx_pop  = i_rd & (i_addr == ADDR_RXDATA);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state <= ST_IDLE;
      rx_cnt   <= 5'h00;
      rx_idx   <= 4'h0;
      rx_shift <= 9'h000;
      rx_perr  <= 1'b0;
    end else if (!port_module_enable) begin
      rx_state <= ST_IDLE;                                                // [RULE7]
    end else if (run) begin
      if (rx_state == ST_IDLE) rx_cnt <= 5'h00;
      else if (tick) rx_cnt <= rx_samp ? 5'h00 : rx_cnt + 5'h01;
      case (rx_state)
        // a floating line can start a spurious frame here
        ST_IDLE: if (!rx_bit) rx_state <= ST_START;                       // [RULE2]
        ST_START: begin
          if (rx_samp) begin
            rx_idx   <= 4'h0;
            rx_shift <= 9'h000;
            rx_perr  <= 1'b0;
            rx_state <= rx_bit ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_samp) begin
            rx_shift[rx_idx] <= rx_bit;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == last_bit) rx_state <= has_par ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY: begin
          if (rx_samp) begin
            rx_perr  <= rx_bit ^ (^rx_shift[7:0]) ^ odd_par;
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: if (rx_samp) rx_state <= ST_IDLE;
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  word_buffer #(.W(RX_WORD_W), .DEPTH(BUF_DEPTH)) u_rx_buffer (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (rx_done),
    .o_in_ready  (buf_room),
    .i_in_data   ({rx_desync, ~rx_bit, rx_perr, rx_shift}),
    .o_out_valid (buf_avail),
    .i_out_ready (rx_pop),
    .o_out_data  (buf_word)
  );

  // =======================================================================
  // wake from sleep
  logic rx_prev;
  logic wake_seen;
  wire  rx_fall   = rx_prev & ~rx_pin_s;
  wire  rx_rise   = ~rx_prev & rx_pin_s;
  wire  wake_fall = i_sleep & port_module_enable & wake_enable & rx_fall; // [RULE4]
  wire  wake_clr  = wake_seen & rx_rise;                                  // [RULE4]

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_prev    <= 1'b1;
      wake_seen  <= 1'b0;
      o_wake_irq <= 1'b0;
      rx_desync  <= 1'b0;
    end else begin
      rx_prev    <= rx_pin_s;
      o_wake_irq <= wake_fall;                                            // [RULE4]
      wake_seen  <= wake_fall | (wake_seen & wake_enable & ~rx_rise);
      // bit timing is lost across sleep: the next word is marked invalid
      rx_desync  <= wake_fall | (rx_desync & ~rx_done);                   // [RULE3]
    end
  end

  // =======================================================================
  // registers
  logic overrun;
  wire  mode_wr = i_wr & (i_addr == ADDR_MODE);
  wire  stat_wr = i_wr & (i_addr == ADDR_STATUS);
  wire  rate_wr = i_wr & (i_addr == ADDR_RATE);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      serial_port_mode_reg <= MODE_RESET;
      rate_div             <= RATE_W'(RATE_RESET);
      overrun              <= 1'b0;
    end else begin
      // a software write wins over a hardware clear in the same cycle
      if (mode_wr) begin
        serial_port_mode_reg <= i_wdata & MODE_WMASK;
      end else begin
        if (wake_clr) serial_port_mode_reg[WAKE_BIT] <= 1'b0;             // [RULE4]
        if (rx_done) serial_port_mode_reg[AUTO_RATE_BIT] <= 1'b0;
      end
      if (rate_wr) rate_div <= i_wdata[RATE_W-1:0];
      overrun <= (rx_done & ~buf_room) |
                 (overrun & ~(stat_wr & i_wdata[STAT_OVERRUN_BIT]));
    end
  end

  wire [15:0] status_word = {12'h000, overrun, (rx_state != ST_IDLE), tx_busy, buf_avail};
  wire [15:0] rx_word     = buf_avail ? {4'h0, buf_word} : 16'h0000;
  wire [15:0] rd_word     = (i_addr == ADDR_MODE)   ? serial_port_mode_reg :
                            (i_addr == ADDR_STATUS) ? status_word :
                            (i_addr == ADDR_RXDATA) ? rx_word :
                            (i_addr == ADDR_RATE)   ? 16'(rate_div) : 16'h0000;

  // =======================================================================
  // outputs
  assign o_tx_oe      = port_module_enable;                               // [RULE7]
  assign o_request_oe = port_module_enable &
                        ((pin_usage_select == PINS_RTS) |
                         (pin_usage_select == PINS_RTS_CTS));             // [RULE7]
  assign o_bclk_oe    = port_module_enable & (pin_usage_select == PINS_CLK);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata                  <= 16'h0000;
      o_tx                     <= 1'b1;
      o_request_to_send_line_b <= 1'b1;
      o_bclk                   <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_word : 16'h0000;
      o_tx    <= tx_enc;
      // simplex: asserted while sending; flow control: asserted while room
      o_request_to_send_line_b <= request_pin_mode ? ~tx_busy : ~buf_room; // [RULE5]
      if (tick) o_bclk <= ~o_bclk;
    end
  end
endmodule : uart_mode_control

// ### test/remote_node.sv
// remote serial node driving the receive pin
// assumes rate 0 in 16x mode: 16 clocks a bit
`timescale 1ns/1ns
module remote_node (
  input  wire logic i_clk,  // bench clock
  input  wire logic i_inv,  // line idles low
  output logic      o_line  // receive pin
);
  logic raw;
  assign o_line = raw ^ i_inv;
  initial raw = 1'b1;
  // ====================================================
  // frame
  // start, eight data lsb first, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk) raw <= f[i];
      repeat (15) @(posedge i_clk);
    end
  endtask : send
  task automatic level(input logic v);
    @(posedge i_clk) raw <= v;
  endtask : level
endmodule : remote_node

// ### test/uart_mode_checker.sv
// port checker for the serial mode block
// assumes binding onto uart_mode_control
`timescale 1ns/1ns
module uart_mode_checker (
  input wire logic                             i_clk,        // clock
  input wire logic                             i_rst_b,      // reset, low
  input wire logic [uart_mode_pkg::ADDR_W-1:0] i_addr,       // index
  input wire logic [15:0]                      i_wdata,      // write data
  input wire logic                             i_wr,         // write
  input wire logic                             i_rd,         // read
  input wire logic [15:0]                      o_rdata,      // read data
  input wire logic                             i_sleep,      // asleep
  input wire logic                             o_tx,         // tx pin
  input wire logic                             o_tx_oe,      // tx driven
  input wire logic                             o_request_oe, // rts driven
  input wire logic                             o_bclk_oe,    // bclk driven
  input wire logic                             o_wake_irq    // wake pulse
);
  import uart_mode_pkg::*;
  logic       en;
  logic       wake;
  logic [1:0] sel;
  logic       mode_wr;
  // shadow of mode bits; hardware clear of wake left out, so it is lax
  assign mode_wr = i_wr && (i_addr == ADDR_MODE);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en   <= 1'b0;
      wake <= 1'b0;
      sel  <= 2'b00;
    end else if (mode_wr) begin
      en   <= i_wdata[ENABLE_BIT];
      wake <= i_wdata[WAKE_BIT];
      sel  <= i_wdata[PIN_SEL_MSB:PIN_SEL_LSB];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence read_mode_s;
    i_rd && (i_addr == ADDR_MODE);
  endsequence
  sequence unarmed_s;
    !(i_sleep && wake && en);
  endsequence
  chk_tx_oe_enable: assert property (o_tx_oe == en)
    else $error("tx enable differs from module enable");
  chk_req_oe_sel: assert property (o_request_oe == (en && sel inside {2'b01, 2'b10}))
    else $error("request pin enable wrong");
  chk_bclk_oe_sel: assert property (o_bclk_oe == (en && sel == 2'b11))
    else $error("rate clock pin enable wrong");
  chk_tx_idle_off: assert property ((!en) [*2] |-> o_tx)
    else $error("tx not idle while disabled");
  chk_rdata_quiet: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_mode_read: assert property (read_mode_s |=> o_rdata[15:14] == {en, 1'b0}
                                  && o_rdata[10:8] == {1'b0, sel})
    else $error("mode readback wrong");
  chk_wake_pulse: assert property (o_wake_irq |=> !o_wake_irq)
    else $error("wake pulse longer than one cycle");
  chk_wake_cause: assert property (not (unarmed_s ##1 o_wake_irq))
    else $error("wake pulse without armed sleep");
endmodule : uart_mode_checker

bind uart_mode_control uart_mode_checker i_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep), .o_tx(o_tx),
  .o_tx_oe(o_tx_oe), .o_request_oe(o_request_oe), .o_bclk_oe(o_bclk_oe),
  .o_wake_irq(o_wake_irq));

// ### test/uart_mode_control_test.sv
// self-checking bench for the serial mode block
// assumes remote_node on the receive pin and the bound checker
`timescale 1ns/1ns
module uart_mode_control_test;
  import uart_mode_pkg::*;
  typedef struct packed {logic [15:0] w; logic [15:0] r; logic [2:0] oe;} row_t;
  localparam row_t ROWS [7] = '{'{16'h8000, 16'h8000, 3'b100},
    '{16'h8100, 16'h8100, 3'b110}, '{16'h8200, 16'h8200, 3'b110},
    '{16'h8300, 16'h8300, 3'b101}, '{16'hffef, 16'hbbef, 3'b101},
    '{16'h4400, 16'h0000, 3'b000}, '{16'h0300, 16'h0300, 3'b000}};
  logic              i_clk, i_rst_b, i_wr, i_rd, i_sleep, i_idle, i_cts_b, rx_inv, rx_line;
  logic [ADDR_W-1:0] i_addr;
  logic [15:0]       i_wdata, o_rdata, seen;
  logic              o_tx, o_tx_oe, rts_b, o_request_oe, o_bclk, o_bclk_oe, o_wake_irq;
  int                bad_count;
  int                num_checks;
  uart_mode_control i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
    .i_idle(i_idle), .i_receive_line(rx_line), .i_cts_b(i_cts_b), .o_tx(o_tx),
    .o_tx_oe(o_tx_oe), .o_request_to_send_line_b(rts_b), .o_request_oe(o_request_oe),
    .o_bclk(o_bclk), .o_bclk_oe(o_bclk_oe), .o_wake_irq(o_wake_irq));
  remote_node i_far (.i_clk(i_clk), .i_inv(rx_inv), .o_line(rx_line));
  // ====================================================
  // tasks
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk16
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [2:0] a, input logic [15:0] e, input string n);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk16(n, e, o_rdata);
  endtask : rdchk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // ====================================================
  // clock, watchdog, tests
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #(100 * 10000);
    bad_count++;
    finish_test();
  end
  initial begin
    {i_rst_b, i_wr, i_rd, i_sleep, i_idle, i_cts_b, rx_inv, i_addr, i_wdata} = '0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdchk(ADDR_MODE, MODE_RESET, "mode reset");
    rdchk(3'h7, 16'h0000, "unmapped read");
    foreach (ROWS[k]) begin
      wr(ADDR_MODE, ROWS[k].w);
      rdchk(ADDR_MODE, ROWS[k].r, "mode row");
      chk16("pin oe", {13'h0, ROWS[k].oe}, {13'h0, o_tx_oe, o_request_oe, o_bclk_oe});
    end
    $display("mode table done");
    wr(ADDR_MODE, 16'h8000);
    i_far.send(8'ha5);
    tick(10);
    rdchk(ADDR_RXDATA, 16'h00a5, "rx word");
    // line left high under inverted polarity looks like a start bit
    wr(ADDR_MODE, 16'h8010);
    tick(18);
    rx_inv <= 1'b1;
    tick(200);
    rdchk(ADDR_RXDATA, 16'h00ff, "spurious word");
    i_far.send(8'h3c);
    tick(10);
    rdchk(ADDR_RXDATA, 16'h003c, "inverted rx");
    rdchk(ADDR_RXDATA, 16'h0000, "buffer empty");
    $display("receive tests done");
    rx_inv <= 1'b0;
    wr(ADDR_MODE, 16'h8080);
    tick(20);
    i_sleep <= 1'b1;
    i_far.level(1'b0);
    seen = '0;
    repeat (10) begin
      tick(1);
      if (o_wake_irq === 1'b1) seen++;
    end
    chk16("wake pulses", 16'h0001, seen);
    i_far.level(1'b1);
    tick(6);
    i_sleep <= 1'b0;
    rdchk(ADDR_MODE, 16'h8000, "wake cleared");
    i_far.send(8'h12);
    tick(10);
    rdchk(ADDR_RXDATA, 16'h0812, "first after wake");
    $display("wake test done");
    wr(ADDR_MODE, 16'h8900);
    tick(2);
    chk16("rts simplex idle", 16'h0001, {15'h0, rts_b});
    wr(ADDR_TXDATA, 16'h005a);
    tick(5);
    chk16("rts simplex busy", 16'h0000, {15'h0, rts_b});
    tick(200);
    chk16("rts simplex done", 16'h0001, {15'h0, rts_b});
    wr(ADDR_MODE, 16'h8100);
    tick(3);
    chk16("rts flow room", 16'h0000, {15'h0, rts_b});
    // clear to send held off, then idle freeze, then release
    i_cts_b <= 1'b1;
    wr(ADDR_MODE, 16'ha200);
    wr(ADDR_TXDATA, 16'h0011);
    tick(5);
    chk16("cts hold", 16'h0001, {15'h0, o_tx});
    {i_idle, i_cts_b} <= 2'b10;
    tick(5);
    chk16("idle freeze", 16'h0001, {15'h0, o_tx});
    i_idle <= 1'b0;
    tick(5);
    chk16("tx start", 16'h0000, {15'h0, o_tx});
    $display("request pin test done");
    tick(170);
    wr(ADDR_MODE, 16'h9000);
    wr(ADDR_TXDATA, 16'h0000);
    tick(10);
    chk16("ir pulse", 16'h0001, {15'h0, o_tx});
    tick(170);
    // fast rate mode: codec must stay out, start bit stays low
    wr(ADDR_MODE, 16'h9008);
    wr(ADDR_TXDATA, 16'h0000);
    tick(5);
    chk16("ir off fast", 16'h0000, {15'h0, o_tx});
    $display("infrared test done");
    finish_test();
  end
endmodule : uart_mode_control_test
